/* File: rtl/dfc_defs.svh */
// Behaviour
// [R1] Debug halt with CAN bit blocks CAN reception
// [R2] Timer four bit freezes its counter
// [R3] Timer three bit freezes its counter
// [R4] Timer two bit freezes its counter
// [R5] Timer one bit freezes its counter
// [R6] Bits eleven, ten freeze bus timeout logic
// [R7] Window watchdog bit freezes its counter
// [R8] Independent watchdog bit freezes its counter
// [R9] Standby bit keeps power, clocks from oscillator
// [R10] Standby exit with bit set resets system
// [R11] Standby bit clear powers off, stops clocks
// [R12] Stop bit keeps clocks running from oscillator
// [R13] Stop bit clear gates clocks; exit restores default
// [R14] Software reprograms clock system after stop exit
// [R15] Sleep bit keeps both clocks from system clock
// [R16] Sleep bit clear stops only bus clock
// [R17] Frozen functions resume without losing state
// [R18] Bits reset to zero, reserved read zero
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH

// Register location in the core CSR space
`define DFC_CSR_ADDR      12'h7c0
`define DFC_CSR_AW        12

// Field positions
`define DFC_BIT_SLEEP     0
`define DFC_BIT_STOP      1
`define DFC_BIT_STANDBY   2
`define DFC_BIT_IWDG      8
`define DFC_BIT_WWDG      9
`define DFC_BIT_BUS1_TO   10
`define DFC_BIT_BUS2_TO   11
`define DFC_BIT_TIM1      12
`define DFC_BIT_TIM2      13
`define DFC_BIT_TIM3      14
`define DFC_BIT_TIM4      15
`define DFC_BIT_CAN       20

// Writable bits and reset value
`define DFC_WR_MASK       32'h0010ff07
`define DFC_RESET_VAL     32'h00000000

// Freeze channel count and low field of the freeze group
`define DFC_NUM_FREEZE    8
`define DFC_FREEZE_LSB    8

`endif

/* File: rtl/dfc_freeze_gate.sv */
`timescale 1ns/1ps
`include "dfc_defs.svh"

// Per-channel run enables: a channel stops only while the core is halted and its freeze bit is set
module dfc_freeze_gate
  import dfc_pkg::*;
#(
  parameter int N = `DFC_NUM_FREEZE
) (
  input  wire logic         ref_clk,    // System clock
  input  wire logic         resetn,     // Async reset, active low
  input  wire logic         halted,     // Core in debug state
  input  wire logic [N-1:0] freeze,     // Freeze selects
  output logic      [N-1:0] run_en      // Per-channel run enable
);

  logic [N-1:0] run_d;
  logic [N-1:0] run_q;

  // Only an enable is gated, so counters hold their value and resume in place
  assign run_d  = ~({N{halted}} & freeze); // [R17]
  assign run_en = run_q;

  // Registered so the enables are glitch-free toward the peripherals
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run_q <= {N{1'b1}};
    end else begin
      run_q <= run_d;
    end
  end

endmodule : dfc_freeze_gate

/* File: rtl/dfc_pkg.sv */
package dfc_pkg;

  // Low-power controller states
  typedef enum logic [1:0] {
    LP_RUN,
    LP_SLEEP,
    LP_STOP,
    LP_STANDBY
  } dfc_lp_state_t;

  // Clock source selection for the free-running and bus clocks
  typedef enum logic [1:0] {
    CLK_SRC_CONFIGURED,
    CLK_SRC_INTERNAL_RC,
    CLK_SRC_NONE
  } dfc_clk_src_t;

endpackage : dfc_pkg

/* File: rtl/dfc_top.sv */
`timescale 1ns/1ps
`include "dfc_defs.svh"

// Debug freeze control register with peripheral freezes and low-power clock/power steering
module dfc_top
  import dfc_pkg::*;
(
  input  wire logic                 ref_clk,                     // System clock, 40 MHz
  input  wire logic                 resetn,                      // Async reset, active low
  input  wire logic [`DFC_CSR_AW-1:0] csr_addr,                  // CSR address
  input  wire logic                 csr_we,                      // CSR write strobe
  input  wire logic                 csr_re,                      // CSR read strobe
  input  wire logic [31:0]          csr_wdata,                   // CSR write data
  output logic      [31:0]          csr_rdata,                   // CSR read data, one cycle after read
  input  wire logic                 core_halted,                 // Core in debug state
  input  wire logic                 sleep_entry,                 // Pulse: core enters sleep
  input  wire logic                 stop_entry,                  // Pulse: core enters stop
  input  wire logic                 standby_entry,               // Pulse: core enters standby
  input  wire logic                 wake_pin,                    // Async wake event level
  output logic                      can_rx_en,                   // CAN receive register may accept data
  output logic                      timer_one_run,               // Timer one counter enable
  output logic                      timer_two_run,               // Timer two counter enable
  output logic                      timer_three_run,             // Timer three counter enable
  output logic                      timer_four_run,              // Timer four counter enable
  output logic                      first_bus_timeout_run,       // First bus timeout logic enable
  output logic                      second_bus_timeout_run,      // Second bus timeout logic enable
  output logic                      window_watchdog_run,         // Window watchdog counter enable
  output logic                      independent_watchdog_run,    // Independent watchdog counter enable
  output logic                      free_running_clock_en,       // Free-running clock gate
  output logic                      bus_clk_en,                  // Bus clock gate
  output dfc_clk_src_t              clk_src,                     // Clock source select
  output logic                      digital_power_en,            // Digital domain power
  output logic                      clk_cfg_restore,             // Pulse: restore reset clock config
  output logic                      sys_reset_req,               // Pulse: system reset request
  output dfc_lp_state_t             lp_state                     // Low-power state
);

  // ---------------- Register ----------------
  logic [31:0]   ctrl_q;
  logic [31:0]   ctrl_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic          csr_hit;
  logic          wr_en;

  // Address decode; unmapped reads return zero
  assign csr_hit = (csr_addr == `DFC_CSR_ADDR);
  assign wr_en   = csr_we & csr_hit;
  // Reserved positions never store, so they read as zero
  assign ctrl_d  = wr_en ? (csr_wdata & `DFC_WR_MASK) : ctrl_q; // [R18]
  assign rdata_d = (csr_re & csr_hit) ? ctrl_q : 32'h00000000;
  assign csr_rdata = rdata_q;

  // Control register and read data
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= `DFC_RESET_VAL; // [R18]
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------- Field decode ----------------
  logic          dbg_sleep;
  logic          dbg_stop;
  logic          dbg_standby;
  logic [`DFC_NUM_FREEZE-1:0] freeze_sel;
  logic [`DFC_NUM_FREEZE:0]   run_all;

  assign dbg_sleep   = ctrl_q[`DFC_BIT_SLEEP];
  assign dbg_stop    = ctrl_q[`DFC_BIT_STOP];
  assign dbg_standby = ctrl_q[`DFC_BIT_STANDBY];
  assign freeze_sel  = ctrl_q[`DFC_FREEZE_LSB +: `DFC_NUM_FREEZE];

  // CAN sits on bit 20, away from the contiguous freeze group, so it rides as an extra channel
  dfc_freeze_gate #(
    .N (`DFC_NUM_FREEZE + 1)
  ) u_freeze (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .halted  (core_halted),
    .freeze  ({ctrl_q[`DFC_BIT_CAN], freeze_sel}),
    .run_en  (run_all)
  );

  // Channel mapping follows the field positions
  assign independent_watchdog_run = run_all[`DFC_BIT_IWDG - `DFC_FREEZE_LSB];    // [R8]
  assign window_watchdog_run      = run_all[`DFC_BIT_WWDG - `DFC_FREEZE_LSB];    // [R7]
  assign first_bus_timeout_run    = run_all[`DFC_BIT_BUS1_TO - `DFC_FREEZE_LSB]; // [R6]
  assign second_bus_timeout_run   = run_all[`DFC_BIT_BUS2_TO - `DFC_FREEZE_LSB]; // [R6]
  assign timer_one_run            = run_all[`DFC_BIT_TIM1 - `DFC_FREEZE_LSB];    // [R5]
  assign timer_two_run            = run_all[`DFC_BIT_TIM2 - `DFC_FREEZE_LSB];    // [R4]
  assign timer_three_run          = run_all[`DFC_BIT_TIM3 - `DFC_FREEZE_LSB];    // [R3]
  assign timer_four_run           = run_all[`DFC_BIT_TIM4 - `DFC_FREEZE_LSB];    // [R2]
  assign can_rx_en                = run_all[`DFC_NUM_FREEZE];                     // [R1]

  // ---------------- Wake synchroniser ----------------
  logic          wake_s1_q;
  logic          wake_s2_q;
  logic          wake_prev_q;
  logic          wake_rise;

  // Two flops before use; edge detect looks only at the second stage
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_s1_q   <= 1'b0;
      wake_s2_q   <= 1'b0;
      wake_prev_q <= 1'b0;
    end else begin
      wake_s1_q   <= wake_pin;
      wake_s2_q   <= wake_s1_q;
      wake_prev_q <= wake_s2_q;
    end
  end

  assign wake_rise = wake_s2_q & ~wake_prev_q;

  // ---------------- Low-power state machine ----------------
  dfc_lp_state_t state_q;
  dfc_lp_state_t state_d;
  logic          restore_d;
  logic          restore_q;
  logic          rst_req_d;
  logic          rst_req_q;

  // Entry requests are taken only from run; wake leaves any low-power state
  always_comb begin
    state_d   = state_q;
    restore_d = 1'b0;
    rst_req_d = 1'b0;
    unique case (state_q)
      LP_RUN: begin
        if (standby_entry) begin
          state_d = LP_STANDBY;
        end else if (stop_entry) begin
          state_d = LP_STOP;
        end else if (sleep_entry) begin
          state_d = LP_SLEEP;
        end
      end
      LP_SLEEP: begin
        // Clock configuration is untouched, so no restore on exit
        if (wake_rise) begin
          state_d = LP_RUN; // [R16]
        end
      end
      LP_STOP: begin
        // Exit always falls back to the reset clock setup; software then rebuilds PLL and crystal
        if (wake_rise) begin
          state_d   = LP_RUN;
          restore_d = 1'b1; // [R13]
        end
      end
      LP_STANDBY: begin
        // Exit is a system reset whether the domain was kept powered or not
        if (wake_rise) begin
          state_d   = LP_RUN;
          rst_req_d = 1'b1; // [R10]
        end
      end
    endcase
  end

  // State and exit pulses
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= LP_RUN;
      restore_q <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      restore_q <= restore_d;
      rst_req_q <= rst_req_d;
    end
  end

  assign lp_state        = state_q;
  assign clk_cfg_restore = restore_q;
  assign sys_reset_req   = rst_req_q;

  // ---------------- Clock and power steering ----------------
  logic          free_running_clock_d;
  logic          hclk_d;
  logic          pwr_d;
  dfc_clk_src_t  src_d;
  logic          free_running_clock_q;
  logic          hclk_q;
  logic          pwr_q;
  dfc_clk_src_t  src_q;

  // Gates follow the state and the debug mode bits; bits are read live so a debugger may change them
  always_comb begin
    free_running_clock_d = 1'b1;
    hclk_d = 1'b1;
    pwr_d  = 1'b1;
    src_d  = CLK_SRC_CONFIGURED;
    unique case (state_q)
      LP_RUN: begin
        src_d = CLK_SRC_CONFIGURED;
      end
      LP_SLEEP: begin
        src_d  = CLK_SRC_CONFIGURED; // [R15]
        hclk_d = dbg_sleep;          // [R15] [R16]
      end
      LP_STOP: begin
        free_running_clock_d = dbg_stop;                                            // [R12] [R13]
        hclk_d = dbg_stop;                                            // [R12] [R13]
        src_d  = dbg_stop ? CLK_SRC_INTERNAL_RC : CLK_SRC_NONE;       // [R12]
      end
      LP_STANDBY: begin
        free_running_clock_d = dbg_standby;                                         // [R9] [R11]
        hclk_d = dbg_standby;                                         // [R9] [R11]
        pwr_d  = dbg_standby;                                         // [R9] [R11]
        src_d  = dbg_standby ? CLK_SRC_INTERNAL_RC : CLK_SRC_NONE;    // [R9]
      end
    endcase
  end

  // Registered gates avoid decode glitches reaching the clock cells
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      free_running_clock_q <= 1'b1;
      hclk_q <= 1'b1;
      pwr_q  <= 1'b1;
      src_q  <= CLK_SRC_CONFIGURED;
    end else begin
      free_running_clock_q <= free_running_clock_d;
      hclk_q <= hclk_d;
      pwr_q  <= pwr_d;
      src_q  <= src_d;
    end
  end

  assign free_running_clock_en = free_running_clock_q;
  assign bus_clk_en            = hclk_q;
  assign digital_power_en      = pwr_q;
  assign clk_src               = src_q;

endmodule : dfc_top

/* File: verification/dfc_chk_asserts.sv */
`timescale 1ns/1ps
`include "dfc_defs.svh"

// Watches the register port, freeze outputs and low-power steering
module dfc_chk
  import dfc_pkg::*;
(
  input wire logic                   ref_clk,               // Clock
  input wire logic                   resetn,                // Reset
  input wire logic [`DFC_CSR_AW-1:0] csr_addr,              // Address
  input wire logic                   csr_re,                // Read strobe
  input wire logic [31:0]            csr_rdata,             // Read data
  input wire logic                   core_halted,           // Debug halt
  input wire logic                   stop_entry,            // Stop pulse
  input wire logic                   standby_entry,         // Standby pulse
  input wire logic                   can_rx_en,             // CAN enable
  input wire logic                   timer_one_run,         // Timer one
  input wire logic                   free_running_clock_en, // Free clock
  input wire logic                   bus_clk_en,            // Bus clock
  input wire dfc_clk_src_t           clk_src,               // Source
  input wire logic                   digital_power_en,      // Power
  input wire logic                   clk_cfg_restore,       // Restore pulse
  input wire logic                   sys_reset_req,         // Reset pulse
  input wire dfc_lp_state_t          lp_state               // State
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Register port and freeze release
  rsvd_zero_a: assert property ((csr_rdata & ~`DFC_WR_MASK) == 32'h0)
    else $error("reserved bits read nonzero");
  unmap_zero_a: assert property (csr_re && csr_addr != `DFC_CSR_ADDR |=> csr_rdata == 32'h0)
    else $error("unmapped read nonzero");
  run_free_a: assert property (!core_halted |=> can_rx_en && timer_one_run)
    else $error("freeze without halt");
  // Gates lag the state by one cycle, so only settled states are judged
  sleep_clk_a: assert property (lp_state == LP_SLEEP && $past(lp_state) == LP_SLEEP
    |-> free_running_clock_en && clk_src == CLK_SRC_CONFIGURED)
    else $error("sleep clocks wrong");
  stop_clk_a: assert property (lp_state == LP_STOP && $past(lp_state) == LP_STOP
    |-> free_running_clock_en == bus_clk_en && digital_power_en
    && clk_src == (bus_clk_en ? CLK_SRC_INTERNAL_RC : CLK_SRC_NONE))
    else $error("stop clocks wrong");
  stby_pwr_a: assert property (lp_state == LP_STANDBY && $past(lp_state) == LP_STANDBY
    |-> free_running_clock_en == digital_power_en && bus_clk_en == digital_power_en
    && clk_src == (digital_power_en ? CLK_SRC_INTERNAL_RC : CLK_SRC_NONE))
    else $error("standby power wrong");
  stby_exit_a: assert property (sys_reset_req |-> lp_state == LP_RUN && $past(lp_state) == LP_STANDBY)
    else $error("stray reset request");
  stop_exit_a: assert property (clk_cfg_restore |-> lp_state == LP_RUN && $past(lp_state) == LP_STOP)
    else $error("stray clock restore");
  stby_enter_a: assert property (lp_state == LP_RUN && standby_entry |=> lp_state == LP_STANDBY)
    else $error("standby not entered");
  stop_enter_a: assert property (lp_state == LP_RUN && stop_entry && !standby_entry |=> lp_state == LP_STOP)
    else $error("stop not entered");
endmodule : dfc_chk

bind dfc_top dfc_chk i_dfc_chk (.*);

/* File: verification/dfc_host.sv */
`timescale 1ns/1ps
`include "dfc_defs.svh"

// Debug host issuing single-word CSR accesses on the falling edge
module dfc_host (
  input  wire logic              ref_clk,   // Clock
  output logic [`DFC_CSR_AW-1:0] csr_addr,  // Address
  output logic                   csr_we,    // Write strobe
  output logic                   csr_re,    // Read strobe
  output logic [31:0]            csr_wdata, // Write data
  input  wire logic [31:0]       csr_rdata  // Read data
);
  // Idle bus at time zero
  initial begin
    csr_addr = 12'h000;
    csr_we = 1'b0;
    csr_re = 1'b0;
    csr_wdata = 32'h0;
  end

  // Data flips once the strobe drops, so stale data never looks valid
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    csr_addr = a;
    csr_wdata = d;
    csr_we = 1'b1;
    @(negedge ref_clk);
    csr_we = 1'b0;
    csr_wdata = ~d;
  endtask : wr

  // Read data stands one cycle after the strobe edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    csr_addr = a;
    csr_re = 1'b1;
    @(negedge ref_clk);
    d = csr_rdata;
    csr_re = 1'b0;
  endtask : rd
endmodule : dfc_host

/* File: verification/test_dfc_top.sv */
`timescale 1ns/1ps
`include "dfc_defs.svh"

module test_dfc_top
  import dfc_pkg::*;
;
  logic ref_clk, resetn, csr_we, csr_re, core_halted, sleep_entry, stop_entry, standby_entry, wake_pin;
  logic [11:0] csr_addr;
  logic [31:0] csr_wdata, csr_rdata;
  logic can_rx_en, timer_one_run, timer_two_run, timer_three_run, timer_four_run;
  logic first_bus_timeout_run, second_bus_timeout_run, window_watchdog_run, independent_watchdog_run;
  logic free_running_clock_en, bus_clk_en, digital_power_en, clk_cfg_restore, sys_reset_req;
  dfc_clk_src_t clk_src;
  dfc_lp_state_t lp_state;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int pos [9] = '{8, 9, 10, 11, 12, 13, 14, 15, 20};
  wire logic [8:0] runs = {can_rx_en, timer_four_run, timer_three_run, timer_two_run, timer_one_run,
    second_bus_timeout_run, first_bus_timeout_run, window_watchdog_run, independent_watchdog_run};
  wire logic [4:0] gates = {free_running_clock_en, bus_clk_en, digital_power_en, clk_src};

  dfc_top i_dfc_top (.*);
  dfc_host i_dfc_host (.*);

  // Clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t reg got %h exp %h", $time, g, e);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [8:0] g, input logic [8:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t out got %h exp %h", $time, g, e);
    end
  endtask : chk_out

  task automatic t_reg;
    logic [31:0] d;
    i_dfc_host.rd(`DFC_CSR_ADDR, d);
    chk_reg(d, 32'h0);
    i_dfc_host.wr(`DFC_CSR_ADDR, 32'hffffffff);
    i_dfc_host.rd(`DFC_CSR_ADDR, d);
    chk_reg(d, 32'h0010ff07);
    i_dfc_host.wr(12'h7c4, 32'h0);
    i_dfc_host.rd(`DFC_CSR_ADDR, d);
    chk_reg(d, 32'h0010ff07);
    i_dfc_host.rd(12'h7c4, d);
    chk_reg(d, 32'h0);
    $display("test reg done");
  endtask : t_reg

  // One freeze bit at a time; only its own channel may stop
  task automatic t_freeze;
    for (int i = 0; i < 9; i++) begin
      i_dfc_host.wr(`DFC_CSR_ADDR, 32'h1 << pos[i]);
      core_halted = 1'b1;
      @(negedge ref_clk);
      chk_out(runs, ~(9'h1 << i));
      core_halted = 1'b0;
      @(negedge ref_clk);
      chk_out(runs, 9'h1ff);
    end
    i_dfc_host.wr(`DFC_CSR_ADDR, 32'h0);
    core_halted = 1'b1;
    @(negedge ref_clk);
    chk_out(runs, 9'h1ff);
    core_halted = 1'b0;
    $display("test freeze done");
  endtask : t_freeze

  // Each low-power mode with its debug bit clear and set; the bit sits at the mode index
  task automatic t_lp;
    logic [4:0] e;
    int n;
    for (int m = 0; m < 3; m++) begin
      for (int b = 0; b < 2; b++) begin
        i_dfc_host.wr(`DFC_CSR_ADDR, 32'(b) << m);
        sleep_entry = (m == 0);
        stop_entry = (m == 1);
        standby_entry = (m == 2);
        @(negedge ref_clk);
        {sleep_entry, stop_entry, standby_entry} = 3'b000;
        @(negedge ref_clk);
        e = (m == 0) ? {1'b1, b[0], 1'b1, CLK_SRC_CONFIGURED}
          : {b[0], b[0], (m == 1) | b[0], b[0] ? CLK_SRC_INTERNAL_RC : CLK_SRC_NONE};
        chk_out({4'h0, gates}, {4'h0, e});
        wake_pin = 1'b1;
        n = 0;
        while (lp_state !== LP_RUN && n < 20) begin
          @(negedge ref_clk);
          n++;
        end
        chk_out({7'h0, clk_cfg_restore, sys_reset_req}, {7'h0, m == 1, m == 2});
        wake_pin = 1'b0;
        @(negedge ref_clk);
        chk_out({4'h0, gates}, {4'h0, 3'b111, CLK_SRC_CONFIGURED});
        // Software rebuilds its clock setup after stop exit, as the host must
        if (m == 1) begin
          i_dfc_host.wr(`DFC_CSR_ADDR, 32'(b) << m);
        end
      end
    end
    $display("test low power done");
  endtask : t_lp

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Hang guard, well past the roughly 110 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    {core_halted, sleep_entry, stop_entry, standby_entry, wake_pin} = 5'h00;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    t_reg();
    t_freeze();
    t_lp();
    close_out();
  end
endmodule : test_dfc_top
